// ---- logic/uvp_host.sv ----
`timescale 1ns/1ps
// What this block does
// - strobe is per-device select, gate is read
// - one strobe pulse of 45 to 55 ms
// - separate pulse per location, any order
// - never program with static high strobe
// - one pulse programs all paralleled devices
// - read back each programmed location
// - supply normal except program and verify
// - supply high in all programming modes
module uvp_host
    import uvp_pkg::*;
#(
    parameter int unsigned PULSE_LEN = PULSE_CYCLES,
    parameter int unsigned SUPPLY_LEN = SUPPLY_CYCLES
)(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req_valid,
    output logic req_ready,
    input wire uvp_req_t req,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic resp_mismatch,
    output logic [10:0] word_address,
    output logic [7:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic [7:0] data_pins_in,
    output logic select_program_strobe_n,
    output logic output_gate_n,
    output logic supply_high
);
    uvp_state_t state, next_state;
    logic [CNT_WIDTH-1:0] cnt, next_cnt;
    uvp_req_t cur, next_cur;
    logic [7:0] sync1, sync2;
    logic [7:0] rdata, next_rdata;
    logic mism, next_mism;
    logic done, next_done;
    logic strobe_hi, next_strobe_hi;
    logic strobe_pin_n, next_strobe_pin_n;
    logic gate_n, next_gate_n;
    logic vpp, next_vpp;
    logic drive, next_drive;

    // pin data comes from outside the clock domain
    always_ff @(posedge core_clk)
    begin
        sync1 <= data_pins_in;
        sync2 <= sync1;
    end

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_cur = cur;
        next_rdata = rdata;
        next_mism = mism;
        next_done = 1'b0;
        next_strobe_hi = strobe_hi;
        next_strobe_pin_n = strobe_pin_n;
        next_gate_n = gate_n;
        next_vpp = vpp;
        next_drive = drive;
        unique case (state)
            UVP_IDLE:
            begin
                next_strobe_hi = 1'b0;
                next_strobe_pin_n = 1'b1;
                next_gate_n = 1'b1;
                next_drive = 1'b0;
                if (req_valid)
                begin
                    next_cur = req;
                    next_cnt = '0;
                    // select before the supply settles, so a high strobe meets a raised supply only during the program pulse
                    next_strobe_pin_n = 1'b0;
                    if (req.program_op)
                    begin
                        next_vpp = 1'b1;
                        next_state = UVP_SUPPLY;
                    end
                    else
                    begin
                        next_vpp = 1'b0;
                        next_gate_n = 1'b0;
                        next_state = UVP_READ;
                    end
                end
            end
            UVP_SUPPLY:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_WIDTH'(SUPPLY_LEN - 1))
                begin
                    next_cnt = '0;
                    next_drive = 1'b1;
                    next_state = UVP_SETUP;
                end
            end
            UVP_SETUP:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_WIDTH'(SETUP_CYCLES - 1))
                begin
                    next_cnt = '0;
                    next_strobe_hi = 1'b1;
                    next_strobe_pin_n = 1'b1;
                    next_state = UVP_PULSE;
                end
            end
            UVP_PULSE:
            begin
                next_cnt = cnt + 1'b1;
                // bounded pulse, never a static level
                if (cnt == CNT_WIDTH'(PULSE_LEN - 1))
                begin
                    next_cnt = '0;
                    next_strobe_hi = 1'b0;
                    next_strobe_pin_n = 1'b0;
                    next_state = UVP_HOLD;
                end
            end
            UVP_HOLD:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_WIDTH'(HOLD_CYCLES - 1))
                begin
                    next_cnt = '0;
                    next_drive = 1'b0;
                    next_gate_n = 1'b0; // verify with supply still raised
                    next_state = UVP_READ;
                end
            end
            UVP_READ:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_WIDTH'(READ_CYCLES + 1))
                begin
                    next_rdata = sync2;
                    // ones in the word leave cells alone, so compare only zeros
                    next_mism = cur.program_op && ((sync2 & ~cur.wdata) != 8'h00);
                    next_gate_n = 1'b1;
                    next_strobe_pin_n = 1'b1;
                    next_vpp = 1'b0;
                    next_state = UVP_DONE;
                end
            end
            UVP_DONE:
            begin
                next_done = 1'b1;
                next_state = UVP_IDLE;
            end
            default:
                next_state = UVP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state <= UVP_IDLE;
            cnt <= '0;
            cur <= '0;
            rdata <= ERASED_WORD;
            mism <= 1'b0;
            done <= 1'b0;
            strobe_hi <= 1'b0;
            strobe_pin_n <= 1'b1;
            gate_n <= 1'b1;
            vpp <= 1'b0;
            drive <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            cur <= next_cur;
            rdata <= next_rdata;
            mism <= next_mism;
            done <= next_done;
            strobe_hi <= next_strobe_hi;
            strobe_pin_n <= next_strobe_pin_n;
            gate_n <= next_gate_n;
            vpp <= next_vpp;
            drive <= next_drive;
        end
    end

    assign req_ready = (state == UVP_IDLE);
    assign resp_valid = done;
    assign resp_data = rdata;
    assign resp_mismatch = mism;
    // address held for the whole operation, one location per pulse
    assign word_address = cur.word_address;
    assign data_pins_out = cur.wdata;
    assign data_pins_oe = drive;
    // strobe low selects for read and inhibits during program idle
    assign select_program_strobe_n = strobe_pin_n;
    assign output_gate_n = gate_n;
    assign supply_high = vpp;

    property p_pulse_len;
        @(posedge core_clk) disable iff (reset)
        $rose(strobe_hi) |-> strobe_hi [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("program pulse too short");

    property p_pulse_ends;
        @(posedge core_clk) disable iff (reset)
        (state == UVP_PULSE && cnt == CNT_WIDTH'(PULSE_LEN - 1)) |=> !strobe_hi;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("program pulse not ended");

    property p_supply_pgm;
        @(posedge core_clk) disable iff (reset)
        strobe_hi |-> (vpp && gate_n && drive);
    endproperty
    a_supply_pgm: assert property (p_supply_pgm) else $error("pulse outside program mode");

    property p_supply_idle;
        @(posedge core_clk) disable iff (reset)
        (state == UVP_IDLE) |-> !vpp;
    endproperty
    a_supply_idle: assert property (p_supply_idle) else $error("supply raised while idle");

    property p_no_contention;
        @(posedge core_clk) disable iff (reset)
        drive |-> gate_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("host drives while gate low");

    property p_addr_stable;
        @(posedge core_clk) disable iff (reset)
        (state != UVP_IDLE && $past(state) != UVP_IDLE) |-> $stable(cur.word_address);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved mid operation");

    property p_verify_follows;
        @(posedge core_clk) disable iff (reset)
        $fell(strobe_hi) |-> ##[1:600] (state == UVP_READ && vpp);
    endproperty
    a_verify_follows: assert property (p_verify_follows) else $error("no verify after pulse");

    property p_read_gate;
        @(posedge core_clk) disable iff (reset)
        (state == UVP_READ) |-> (!gate_n && !strobe_hi && !drive && !strobe_pin_n);
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("bad pin levels in read");

    // with the supply raised the strobe pin is low except for the program pulse
    property p_inhibit_pin;
        @(posedge core_clk) disable iff (reset)
        vpp |-> (strobe_pin_n == strobe_hi);
    endproperty
    a_inhibit_pin: assert property (p_inhibit_pin) else $error("strobe pin wrong under raised supply");

    c_read: cover property (@(posedge core_clk) disable iff (reset) resp_valid && !cur.program_op);
    c_prog: cover property (@(posedge core_clk) disable iff (reset) resp_valid && cur.program_op);
    c_mism: cover property (@(posedge core_clk) disable iff (reset) resp_valid && resp_mismatch);
endmodule : uvp_host

// ---- logic/uvp_pkg.sv ----
package uvp_pkg;
    localparam int unsigned CLK_FREQ_HZ = 250_000_000;
    localparam int unsigned ADDR_WIDTH = 11;
    localparam int unsigned DATA_WIDTH = 8;
    // nominal program pulse, inside the 45..55 ms window
    localparam int unsigned PULSE_NOM_MS = 50;
    localparam int unsigned PULSE_MIN_MS = 45;
    localparam int unsigned PULSE_MAX_MS = 55;
    localparam int unsigned PULSE_CYCLES = PULSE_NOM_MS * (CLK_FREQ_HZ / 1000);
    // setup and hold for address, data and output gate around the pulse
    localparam int unsigned SETUP_US = 2;
    localparam int unsigned HOLD_US = 2;
    localparam int unsigned SETUP_CYCLES = SETUP_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned HOLD_CYCLES = HOLD_US * (CLK_FREQ_HZ / 1_000_000);
    // output gate low to data valid, 120 ns, plus margin; rounded up
    localparam int unsigned READ_NS = 450;
    localparam int unsigned READ_CYCLES = (READ_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    // supply settle time after switching the programming supply
    localparam int unsigned SUPPLY_US = 10;
    localparam int unsigned SUPPLY_CYCLES = SUPPLY_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned CNT_WIDTH = 24;
    localparam logic [7:0] ERASED_WORD = 8'hFF;

    typedef enum logic [2:0] {
        UVP_IDLE = 3'b000,
        UVP_SETUP = 3'b001,
        UVP_PULSE = 3'b011,
        UVP_HOLD = 3'b010,
        UVP_READ = 3'b110,
        UVP_SUPPLY = 3'b111,
        UVP_DONE = 3'b101
    } uvp_state_t;

    typedef struct packed {
        logic [10:0] word_address;
        logic [7:0] wdata;
        logic program_op;
    } uvp_req_t;

    typedef struct packed {
        logic [10:0] word_address;
        logic [7:0] data_out;
        logic data_oe;
        logic select_program_strobe_n;
        logic output_gate_n;
        logic supply_high;
    } uvp_pins_t;
endpackage : uvp_pkg

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import uvp_pkg::*;
;
    localparam int unsigned PLEN = 20;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    uvp_req_t req = '0;
    logic stuck_cell = 1'b0;
    logic req_ready, resp_valid, resp_mismatch, data_pins_oe, select_program_strobe_n, output_gate_n, supply_high;
    logic [10:0] word_address;
    logic [7:0] resp_data, data_pins_out, data_pins_in;
    logic [8:0] expect_q [$];
    logic [7:0] mirror [0:2047];
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    uvp_host #(.PULSE_LEN(PLEN), .SUPPLY_LEN(4)) DUT (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_mismatch(resp_mismatch), .word_address(word_address), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in), .select_program_strobe_n(select_program_strobe_n),
        .output_gate_n(output_gate_n), .supply_high(supply_high));
    uvp_eprom_model #(.PULSE_LEN(PLEN)) rom (.core_clk(core_clk), .stuck_cell(stuck_cell),
        .word_address(word_address), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
        .select_program_strobe_n(select_program_strobe_n), .output_gate_n(output_gate_n),
        .supply_high(supply_high), .data_pins_in(data_pins_in));

    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // valid stays up between back-to-back requests, dropped only after the last
    task automatic issue(input logic [10:0] a, input logic [7:0] d, input logic p, input logic last);
        req <= '{word_address: a, wdata: d, program_op: p};
        req_valid <= 1'b1;
        forever
        begin
            @(negedge core_clk);
            if (req_ready === 1'b1)
                break;
        end
        @(posedge core_clk);
        if (p && !stuck_cell)
            mirror[a] = mirror[a] & d;
        expect_q.push_back({mirror[a], p && ((mirror[a] & ~d) != 8'h00)});
        if (last)
            req_valid <= 1'b0;
    endtask : issue

    task automatic drain(input string name);
        repeat (3000)
        begin
            @(posedge core_clk);
            if (expect_q.size() == 0)
                break;
        end
        n_compared++;
        if (expect_q.size() != 0)
        begin
            fails++;
            $display("wrong value at %0t: no answer", $time);
        end
        $display("%s done", name);
    endtask : drain

    always @(negedge core_clk)
    begin
        if (!reset && resp_valid === 1'b1)
        begin
            n_compared++;
            if (expect_q.size() == 0 || {resp_data, resp_mismatch} !== expect_q[0])
            begin
                fails++;
                $display("wrong value at %0t: answer %h %b", $time, resp_data, resp_mismatch);
            end
            if (expect_q.size() != 0)
                void'(expect_q.pop_front());
        end
        if (!reset && ((req_ready === 1'b1 && supply_high !== 1'b0)
            || (output_gate_n === 1'b0 && select_program_strobe_n !== 1'b0)
            || (data_pins_oe === 1'b1 && (supply_high !== 1'b1 || output_gate_n !== 1'b1))))
        begin
            fails++;
            $display("wrong value at %0t: pin levels", $time);
        end
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fails++;
            $display("wrong value at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    initial
    begin
        logic [10:0] a;
        logic [7:0] d;
        void'($urandom(37292));
        foreach (mirror[i]) mirror[i] = ERASED_WORD;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        issue(11'h000, 8'h00, 1'b0, 1'b0);
        issue(11'h7FF, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++)
            issue(11'($urandom), 8'h00, 1'b0, i == 3);
        drain("erased reads");
        // random locations in random order, each with a later plain read
        for (int i = 0; i < 6; i++)
        begin
            a = 11'($urandom);
            d = 8'($urandom);
            issue(a, d, 1'b1, 1'b0);
            issue(a, 8'h00, 1'b0, i == 5);
        end
        drain("program and verify");
        issue(11'h7FF, 8'h0F, 1'b1, 1'b0);
        issue(11'h7FF, 8'hF0, 1'b1, 1'b0);
        issue(11'h7FF, 8'hFF, 1'b1, 1'b0);
        issue(11'h7FF, 8'h00, 1'b0, 1'b1);
        drain("no return to one");
        // weak cell ignores the pulse, so the verify has to flag it
        stuck_cell <= 1'b1;
        issue(11'h001, 8'h5A, 1'b1, 1'b1);
        drain("verify mismatch");
        stuck_cell <= 1'b0;
        tally_and_finish();
    end
endmodule : tb_top

// ---- testbench/uvp_eprom_model.sv ----
`timescale 1ns/1ps
module uvp_eprom_model
    import uvp_pkg::*;
#(
    parameter int unsigned PULSE_LEN = 20
)(
    input wire logic core_clk,
    input wire logic stuck_cell,
    input wire logic [10:0] word_address,
    input wire logic [7:0] data_pins_out,
    input wire logic data_pins_oe,
    input wire logic select_program_strobe_n,
    input wire logic output_gate_n,
    input wire logic supply_high,
    output logic [7:0] data_pins_in
);
    logic [7:0] mem [0:2047];
    logic [7:0] last_out = ERASED_WORD;
    logic strobe_d = 1'b1;
    int unsigned width = 0;
    initial foreach (mem[i]) mem[i] = ERASED_WORD;
    // no pull on these pins, so a released bus shows the inverse of the last value
    always_comb
    begin
        if (!select_program_strobe_n && !output_gate_n)
            data_pins_in = mem[word_address];
        else
            data_pins_in = ~last_out;
    end
    always @(posedge core_clk)
    begin
        if (!select_program_strobe_n && !output_gate_n)
            last_out <= mem[word_address];
        strobe_d <= select_program_strobe_n;
        width <= select_program_strobe_n ? width + 1 : 0;
        // only a bounded high pulse ending in program mode writes; low strobe inhibits
        if (strobe_d && !select_program_strobe_n && supply_high && output_gate_n && data_pins_oe && !stuck_cell
            && width * 50 >= PULSE_LEN * 45 && width * 50 <= PULSE_LEN * 55)
            mem[word_address] <= mem[word_address] & data_pins_out;
    end
endmodule : uvp_eprom_model
